// ### src/wdt_pkg.sv
// constants, register map and encodings for the windowed watchdog
package wdt_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'h16; // watchdog_control
    localparam logic [7:0] IDX_SERVICE = 8'h17; // service_register
    localparam logic [7:0] IDX_STATUS  = 8'h18; // sticky event flags
    localparam logic [7:0] IDX_CLEAR   = 8'h19; // write-one-to-clear
    localparam logic [7:0] IDX_ENABLE  = 8'h1a; // interrupt enables
    localparam logic [7:0] IDX_COUNT   = 8'h1b; // live period count
    localparam int         ADDR_W      = 8;     // decoded address bits

    // control field positions
    localparam int CTL_WINDOW   = 4;            // window_mode_select
    localparam int CTL_SUPPRESS = 3;            // reset_suppress
    localparam int CTL_SEL_HI   = 2;            // period_select msb
    localparam int SEL_W        = 3;            // period_select width

    // reset values
    localparam logic [2:0] SEL_RESET    = 3'h7;
    localparam logic       WINDOW_RESET = 1'b0;

    // service sequence values
    localparam logic [7:0] SVC_FIRST  = 8'h55;
    localparam logic [7:0] SVC_SECOND = 8'haa;

    // status / interrupt bit positions
    localparam int EV_TIMEOUT = 0;              // period expired
    localparam int EV_BADVAL  = 1;              // illegal service value
    localparam int EV_EARLY   = 2;              // write before window
    localparam int EV_CLKMON  = 3;              // clock monitor failure
    localparam int EV_RESTART = 4;              // successful service
    localparam int EV_W       = 5;

    // timing: sys clock 250 MHz, crystal-derived clock near 8 MHz
    localparam int SYS_HZ      = 250_000_000;
    localparam int CRYSTAL_HZ  = 8_000_000;
    localparam int CRYSTAL_DIV = SYS_HZ / CRYSTAL_HZ; // rounds down: 31
    localparam int XDIV_W      = 5;
    localparam int PRE_LOG2    = 11;            // shared prescale 2^11
    localparam int SEL1_LOG2   = 13;            // shortest period 2^13
    localparam int CNT_W       = 13;            // up to 2^23 / 2^11
endpackage : wdt_pkg

// ### src/wdt_prescaler.sv
// free-running crystal clock divider and shared prescale chain
`timescale 1ns/1ns
module wdt_prescaler
    import wdt_pkg::*;
(
    input  wire logic clk_sys,  // system clock
    input  wire logic arst_n,   // async reset, active low
    output logic      crystal_en, // crystal-derived clock enable
    output logic      pre_tick    // one pulse per 2^11 crystal ticks
);
    logic [XDIV_W-1:0]   xdiv_q;   // sys-to-crystal divider
    logic [PRE_LOG2-1:0] pre_q;    // shared prescale chain

    // crystal-derived clock as a one-cycle enable
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            xdiv_q     <= '0;
            crystal_en <= 1'b0;
        end else if (xdiv_q == XDIV_W'(CRYSTAL_DIV - 1)) begin
            xdiv_q     <= '0;
            crystal_en <= 1'b1;
        end else begin
            xdiv_q     <= xdiv_q + 1'b1;
            crystal_en <= 1'b0;
        end
    end

    // never cleared by watchdog
    // the chain is shared with the periodic interrupt chain, so a
    // watchdog restart cannot touch it; phase slips up to one step
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pre_q    <= '0;
            pre_tick <= 1'b0;
        end else begin
            pre_tick <= 1'b0;
            if (crystal_en) begin
                pre_q <= pre_q + 1'b1;
                pre_tick <= &pre_q;
            end
        end
    end
endmodule : wdt_prescaler

// ### src/windowed_watchdog_timer.sv
// windowed watchdog timer with apb register access
`timescale 1ns/1ns
module windowed_watchdog_timer
    import wdt_pkg::*;
(
    input  wire logic        clk_sys,       // 250 mhz system clock
    input  wire logic        arst_n,        // async reset, active low
    input  wire logic        special_mode,  // 1: special, 0: normal
    input  wire logic        clk_mon_fail,  // clock monitor failure
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb direction
    input  wire logic [31:0] paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // unmapped address
    output logic             irq,           // level interrupt
    output logic             sys_reset_req  // one-cycle reset request
);
    import wdt_pkg::*;

    // timing chain: the system clock is divided down to a crystal-rate
    // enable, which feeds a free-running prescale chain shared with the
    // periodic interrupt chain; each prescale step advances the period
    // counter by one while a rate is selected
    // hazard: the divider rounds down, so the crystal rate runs a little
    // fast and every period ends slightly early against the nominal
    // figure; a user needing exact periods must retune the divider

    // steps per period: the rate code picks a power of two, and the
    // prescale step is removed; the two longest codes differ by one power
    // period length in prescale ticks for a rate code
    function automatic logic [CNT_W-1:0] period_len(
        input logic [SEL_W-1:0] sel
    );
        logic [CNT_W-1:0] one;
        one = CNT_W'(1);
        case (sel)
            3'h1:    period_len = one << (SEL1_LOG2 - PRE_LOG2);
            3'h2:    period_len = one << (SEL1_LOG2 + 2 - PRE_LOG2);
            3'h3:    period_len = one << (SEL1_LOG2 + 4 - PRE_LOG2);
            3'h4:    period_len = one << (SEL1_LOG2 + 6 - PRE_LOG2);
            3'h5:    period_len = one << (SEL1_LOG2 + 8 - PRE_LOG2);
            3'h6:    period_len = one << (SEL1_LOG2 + 9 - PRE_LOG2);
            3'h7:    period_len = one << (SEL1_LOG2 + 10 - PRE_LOG2);
            default: period_len = '0;       // code 000: off
        endcase
    endfunction : period_len

    // only the low address bits are decoded; upper bits must be zero
    // register index from a byte address, or all ones if unaligned
    function automatic logic [ADDR_W-1:0] reg_index(
        input logic [31:0] a
    );
        if (a[1:0] != 2'h0 || a[31:ADDR_W+2] != '0)
            reg_index = '1;
        else
            reg_index = a[ADDR_W+1:2];
    endfunction : reg_index

    logic                crystal_en;   // crystal-derived clock enable
    logic                pre_tick;     // shared prescale step
    logic                window_q;     // window_mode_select
    logic                suppress_q;   // reset_suppress
    logic [SEL_W-1:0]    sel_q;        // period_select
    logic                locked_q;     // write-once bits used up
    logic                strap_done_q; // mode strap taken
    logic [CNT_W-1:0]    cnt_q;        // prescale ticks since restart
    logic                armed_q;      // first step seen
    logic [EV_W-1:0]     status_q;     // sticky events
    logic [EV_W-1:0]     enable_q;     // interrupt enables
    logic                req_sent_q;   // a request already issued
    logic [ADDR_W-1:0]   idx;          // decoded register index
    logic                mapped;       // address hits a register
    logic                acc;          // transfer completes now
    logic                wr;           // write completes now
    logic [7:0]          wbyte;        // low byte of write data
    logic [CNT_W-1:0]    plen;         // active period length
    logic [CNT_W-1:0]    wstart;       // window opening count
    logic                running;      // period selected
    logic                in_window;    // last quarter reached
    logic                svc_wr;       // write to service register
    logic                ev_timeout;   // period expired
    logic                ev_badval;    // illegal service value
    logic                ev_early;     // service write too soon
    logic                ev_restart;   // valid second step
    logic [EV_W-1:0]     ev_vec;       // event bundle
    logic [EV_W-1:0]     clr_vec;      // software clear bits
    logic                fail;         // any reset cause
    logic [31:0]         rdata;        // read mux

    wdt_prescaler u_pre (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .crystal_en (crystal_en),
        .pre_tick   (pre_tick)
    );

    // register map, one aligned word each, data in the low byte except the 13-bit count:
    //   control  window select, reset suppress, rate code
    //   service  write-only sequence port, always reads zero
    //   status   sticky events, cleared through the clear word
    //   enable   interrupt mask of the same layout
    //   count    live prescale-step count, read-only
    // anything else, or an unaligned byte address, answers with an error
    // apb decode; request complete when pready already high
    assign idx    = reg_index(paddr);
    assign mapped = (idx == IDX_CONTROL) || (idx == IDX_SERVICE) ||
                    (idx == IDX_STATUS)  || (idx == IDX_CLEAR)   ||
                    (idx == IDX_ENABLE)  || (idx == IDX_COUNT);
    assign acc    = psel && penable && pready;
    assign wr     = acc && pwrite && mapped;
    assign wbyte  = pwdata[7:0];
    assign svc_wr = wr && (idx == IDX_SERVICE);

    assign plen    = period_len(sel_q);
    assign running = (sel_q != '0);
    assign wstart    = plen - (plen >> 2);
    assign in_window = (cnt_q >= wstart);

    // service events; the three write events are single-cycle strobes taken at the
    // completing apb edge, so a write never counts twice; expiry strobes on pre_tick
    // order of checks: a value that is neither sequence step is a bad
    // value first, and only a legal step can be early; this keeps one
    // cause per write in the status word
    // expiry without service
    assign ev_timeout = running && pre_tick && (cnt_q == plen - 1'b1);
    assign ev_badval  = svc_wr && (wbyte != SVC_FIRST) &&
                        (wbyte != SVC_SECOND);
    // 0x55 inside the window is harmless
    assign ev_early   = svc_wr && running && window_q && !in_window &&
                        !ev_badval;
    assign ev_restart = svc_wr && (wbyte == SVC_SECOND) && armed_q &&
                        !ev_early;

    assign ev_vec = {ev_restart, clk_mon_fail, ev_early, ev_badval,
                     ev_timeout};
    assign clr_vec = (wr && idx == IDX_CLEAR) ? pwdata[EV_W-1:0] : '0;
    assign fail    = ev_timeout || ev_badval || ev_early || clk_mon_fail;

    // the answer is registered, so every transfer costs exactly one
    // wait state; read data is captured one edge before completion,
    // which is safe because the master holds the address steady
    // trade-off: a fixed wait state keeps the read mux off the bus path
    // apb handshake: one wait state, then ready for one cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= (pwrite || !mapped) ? '0 : rdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
    end

    // read mux; unused bits read as zero
    always_comb begin
        rdata = '0;
        case (idx)
            IDX_CONTROL: begin
                rdata[CTL_WINDOW]   = window_q;
                rdata[CTL_SUPPRESS] = suppress_q;
                rdata[CTL_SEL_HI:0] = sel_q;
            end
            IDX_SERVICE: rdata = '0;
            IDX_STATUS:  rdata[EV_W-1:0] = status_q;
            IDX_ENABLE:  rdata[EV_W-1:0] = enable_q;
            IDX_COUNT:   rdata[CNT_W-1:0] = cnt_q;
            default:     rdata = '0;    // clear is write-only
        endcase
    end

    // write-once window and rate
    // in normal mode the first control write uses up the lock, even
    // if it rewrites the same values; special mode never locks
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            window_q <= WINDOW_RESET;
            sel_q    <= SEL_RESET;
            locked_q <= 1'b0;
        end else if (wr && idx == IDX_CONTROL) begin
            if (special_mode || !locked_q) begin
                window_q <= pwdata[CTL_WINDOW];
                sel_q    <= pwdata[CTL_SEL_HI:0];
            end
            if (!special_mode) begin
                locked_q <= 1'b1;
            end
        end
    end

    // suppress writable only in special
    // mode is a level, so it is caught on the first clocked edge
    // after reset release instead of inside the async branch
    // normal mode can never clear suppress, so a strapped special part
    // keeps its resets off until software changes it or a new reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            suppress_q   <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            suppress_q   <= special_mode;
            strap_done_q <= 1'b1;
        end else if (wr && idx == IDX_CONTROL && special_mode) begin
            suppress_q <= pwdata[CTL_SUPPRESS];
        end
    end

    // the counter holds at zero while the rate is off, so a later
    // enable always starts a full period; a restart or an expiry
    // clears it, but the shared prescale chain keeps its phase
    // period counter in prescale steps
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (!running || ev_restart || ev_timeout) begin
            cnt_q <= '0;
        end else if (pre_tick) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // limitation: a lone second step is ignored rather than punished unless it lands before the window,
    // and a timeout, bad value or early write drops the armed state so a stale first step
    // cannot complete a later sequence; a clock monitor failure leaves it armed
    // service sequence: first step arms, second completes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            armed_q <= 1'b0;
        end else if (ev_restart || ev_timeout || ev_badval ||
                     ev_early) begin
            armed_q <= 1'b0;
        end else if (svc_wr && wbyte == SVC_FIRST) begin
            armed_q <= 1'b1;
        end
    end

    // the clear word is write-one-to-clear; zero bits leave their
    // flags alone
    // sticky status; a new event wins over a same-cycle clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~clr_vec) | ev_vec;
        end
    end

    // enables reset to zero, so no interrupt before software opts in
    // interrupt enables
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            enable_q <= '0;
        end else if (wr && idx == IDX_ENABLE) begin
            enable_q <= pwdata[EV_W-1:0];
        end
    end

    // next status is used so the line moves on the same edge as the
    // status word, never a cycle behind it
    // level interrupt from enabled sticky bits
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status_q & ~clr_vec) | ev_vec) & enable_q);
        end
    end

    // suppress blocks all requests
    // the system is expected to reset us; until then no repeats
    // suppress is read as held before the event edge; a write that
    // sets it in the same cycle as a failure does not stop the request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sys_reset_req <= 1'b0;
            req_sent_q    <= 1'b0;
        end else begin
            sys_reset_req <= 1'b0;
            if (fail && !suppress_q && !req_sent_q) begin
                sys_reset_req <= 1'b1;
                req_sent_q    <= 1'b1;
            end
        end
    end
endmodule : windowed_watchdog_timer

// ### tb/wdt_props.sv
// assertion checker for the windowed watchdog register and reset ports
`timescale 1ns/1ns
module wdt_props
    import wdt_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        special_mode,
    input wire logic        clk_mon_fail,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        sys_reset_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // byte addresses of the two words the mirrors decode
    localparam logic [31:0] SVC_ADDR = {22'h0, IDX_SERVICE, 2'b00};
    localparam logic [31:0] CTL_ADDR = {22'h0, IDX_CONTROL, 2'b00};
    logic taken;   // write or read completes this edge
    logic svc_bad; // service write of an illegal value
    logic strap_q; // first edge after release seen
    logic supp_q;  // mirror of the reset suppress bit
    logic fired_q; // a reset request was already given
    assign taken = psel && penable && pready;
    assign svc_bad = taken && pwrite && paddr == SVC_ADDR &&
        pwdata[7:0] != SVC_FIRST && pwdata[7:0] != SVC_SECOND;
    // suppress mirror: strap at first edge, then special-mode writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strap_q <= 1'b0;
            supp_q  <= 1'b0;
        end else if (!strap_q) begin
            strap_q <= 1'b1;
            supp_q  <= special_mode;
        end else if (taken && pwrite && paddr == CTL_ADDR &&
                     special_mode) begin
            supp_q <= pwdata[CTL_SUPPRESS];
        end
    end
    // request history, cleared only by reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fired_q <= 1'b0;
        end else if (sys_reset_req) begin
            fired_q <= 1'b1;
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence one_wait_s;
        !pready ##1 pready;
    endsequence
    a_ready_one_wait: assert property (setup_s |=> one_wait_s)
        else $error("pready not after exactly one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside answer");
    a_svc_read_zero: assert property (
        taken && !pwrite && paddr == SVC_ADDR |-> prdata == 32'h0)
        else $error("service register read not zero");
    a_unaligned_err: assert property (
        taken && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("unaligned access not refused");
    a_badval_reset: assert property (
        svc_bad && !supp_q && !fired_q |-> ##[1:2] sys_reset_req)
        else $error("bad service value gave no reset request");
    a_monitor_reset: assert property (
        clk_mon_fail && !supp_q && !fired_q |-> ##[1:2] sys_reset_req)
        else $error("monitor failure gave no reset request");
    a_suppress_blocks: assert property (
        supp_q && $past(supp_q) && $past(supp_q, 2) |-> !sys_reset_req)
        else $error("reset request while suppressed");
    a_reset_once: assert property (
        sys_reset_req |-> !fired_q ##1 !sys_reset_req)
        else $error("more than one reset request");
endmodule : wdt_props

bind windowed_watchdog_timer wdt_props u_props (.clk_sys(clk_sys),
    .arst_n(arst_n),
    .special_mode(special_mode), .clk_mon_fail(clk_mon_fail), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .sys_reset_req(sys_reset_req));

// ### tb/tb_windowed_watchdog_timer.sv
// self-checking bench for the windowed watchdog over apb
`timescale 1ns/1ns
module tb_windowed_watchdog_timer;
    import wdt_pkg::*;
    localparam logic [31:0] A_CTL = {22'h0, IDX_CONTROL, 2'b00};
    localparam logic [31:0] A_SVC = {22'h0, IDX_SERVICE, 2'b00};
    localparam logic [31:0] A_ST  = {22'h0, IDX_STATUS, 2'b00};
    localparam logic [31:0] A_CLR = {22'h0, IDX_CLEAR, 2'b00};
    localparam logic [31:0] A_EN  = {22'h0, IDX_ENABLE, 2'b00};
    localparam logic [31:0] A_CNT = {22'h0, IDX_COUNT, 2'b00};
    logic        clk_sys, arst_n, special_mode, clk_mon_fail;
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic        sys_reset_req, err_v;
    logic [31:0] paddr, pwdata, prdata, rd_v;
    int          failures, total_checks, req_cnt;
    windowed_watchdog_timer dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .special_mode(special_mode), .clk_mon_fail(clk_mon_fail),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .sys_reset_req(sys_reset_req));
    // 250 mhz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // count reset request pulses; a real system would reboot here
    always @(posedge clk_sys) begin
        if (sys_reset_req === 1'b1) req_cnt++;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // bounded wait: a hung slave must not stall the run
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t no pready", $time);
            close_out;
        end else begin
            rd_v = prdata;
            err_v = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_sys);
        end
    endtask : apb
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_v, exp);
    endtask : rd
    task automatic do_reset(input logic m);
        arst_n <= 1'b0;
        special_mode <= m;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        req_cnt = 0;
    endtask : do_reset
    // normal mode: defaults, write-once, bad value, early write, irq
    task automatic t_normal;
        do_reset(1'b0);
        rd(A_CTL, 32'h07);
        rd(A_EN, 32'h0);
        rd(A_SVC, 32'h0);
        // window mode only with a rate longer than the shortest
        apb(1'b1, A_CTL, 32'h1a);
        rd(A_CTL, 32'h12);
        apb(1'b1, A_CTL, 32'h05);
        rd(A_CTL, 32'h12);
        apb(1'b1, A_EN, 32'h04);
        apb(1'b1, A_SVC, 32'h33);
        repeat (4) @(posedge clk_sys);
        chk(32'(req_cnt), 32'h1);
        rd(A_ST, 32'h02);
        chk({31'h0, irq}, 32'h0);
        // count is still zero, far before the window opens
        apb(1'b1, A_SVC, {24'h0, SVC_FIRST});
        rd(A_ST, 32'h06);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, A_CLR, 32'h06);
        rd(A_ST, 32'h0);
        chk({31'h0, irq}, 32'h0);
        chk(32'(req_cnt), 32'h1);
        apb(1'b0, 32'h100, 32'h0);
        chk({31'h0, err_v}, 32'h1);
        chk(rd_v, 32'h0);
        apb(1'b0, A_SVC + 32'h1, 32'h0);
        chk({31'h0, err_v}, 32'h1);
        $display("test normal done");
    endtask : t_normal
    // special mode: suppress, rewrites, service sequence, monitor
    task automatic t_special;
        do_reset(1'b1);
        rd(A_CTL, 32'h0f);
        apb(1'b1, A_SVC, 32'h33);
        clk_mon_fail <= 1'b1;
        @(posedge clk_sys);
        clk_mon_fail <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(32'(req_cnt), 32'h0);
        rd(A_ST, 32'h0a);
        apb(1'b1, A_CTL, 32'h08);
        rd(A_CNT, 32'h0);
        apb(1'b1, A_CTL, 32'h01);
        rd(A_CTL, 32'h01);
        apb(1'b1, A_CLR, 32'h1f);
        // second step without the first is ignored
        apb(1'b1, A_SVC, {24'h0, SVC_SECOND});
        rd(A_ST, 32'h0);
        apb(1'b1, A_SVC, {24'h0, SVC_FIRST});
        apb(1'b1, A_SVC, {24'h0, SVC_SECOND});
        rd(A_ST, 32'h10);
        // first prescale step lands one chain length after release
        repeat ((1 << PRE_LOG2) * CRYSTAL_DIV + 512) @(posedge clk_sys);
        rd(A_CNT, 32'h1);
        apb(1'b1, A_SVC, {24'h0, SVC_FIRST});
        apb(1'b1, A_SVC, {24'h0, SVC_SECOND});
        rd(A_CNT, 32'h0);
        clk_mon_fail <= 1'b1;
        @(posedge clk_sys);
        clk_mon_fail <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(32'(req_cnt), 32'h1);
        $display("test special done");
    endtask : t_special
    initial begin
        arst_n = 1'b0;
        special_mode = 1'b0;
        clk_mon_fail = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        failures = 0;
        total_checks = 0;
        req_cnt = 0;
        t_normal;
        t_special;
        close_out;
    end
endmodule : tb_windowed_watchdog_timer
